/* hdl/alarm_supervisor.sv */
// fault supervisor for a bidirectional dc-dc converter
// ----------------------------------------------------------------
// How it works
// [R01] heavy alarm drives fault line, stops conversion, opens output good
// [R02] heavy alarm latched until serial, pin or push-switch clear request
// [R03] after clear, conversion restarts only while operation command valid
// [R04] system alert ignores clears; only power cycle clears it
// [R05] light alarm stops conversion, opens output good, no fault line
// [R06] light alarm self-clears; conversion restarts if mode command valid
// [R07] current alarm status readable by host
// [R08] battery overvoltage vs adjustable threshold, class depends on mode
// [R09] battery undervoltage vs adjustable threshold, ignored in ramp-up
// [R10] battery overcurrent vs fixed limit, always heavy
// [R11] grid voltage alarms adjustable, mode classed; grid overcurrent heavy
// [R12] hardware overcurrent heavy except waiting, where ignored
// [R13] external stop input raises heavy converter-stop alarm
// [R14] fan slow is heavy except in waiting and ramp-up
// [R15] primary and secondary heatsink detectors always heavy
// [R16] internal temperature over limit, heavy or light by mode
// [R17] any internal abnormality raises system alert, always heavy
// [R18] regen cc shutdown when current and battery power both over limit
// [R19] adjustable thresholds host writable, fixed ones not
// [R20] host stops charging before power cycling for system alert
// [R21] per item active flag and class captured when raised
// ----------------------------------------------------------------
`timescale 1ns/100ps
`include "alarm_defs.svh"
module alarm_supervisor #(
    parameter int N = `ALM_COUNT,
    parameter int DW = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    // measured values, same clock domain
    input wire logic [DW-1:0] i_bat_volt,
    input wire logic [DW-1:0] i_bat_curr,
    input wire logic [DW-1:0] i_grid_volt,
    input wire logic [DW-1:0] i_grid_curr,
    input wire logic [DW-1:0] i_fan_rpm,
    input wire logic [DW-1:0] i_temp_c,
    input wire logic [DW-1:0] i_bat_power,
    input wire logic i_regen_cc,
    // pin level detector inputs
    input wire logic i_hw_oc_pin,
    input wire logic i_ext_stop_pin,
    input wire logic i_hs_pri_pin,
    input wire logic i_hs_sec_pin,
    input wire logic i_fault_clear_input,
    input wire logic i_reset_switch,
    // internal abnormality
    input wire logic i_sys_abnormal,
    // operation command from serial side
    input wire alarm_pkg::op_mode_type i_mode,
    input wire logic i_run_cmd,
    // serial side requests
    input wire logic i_serial_clear,
    input wire logic i_thr_wr,
    input wire logic [1:0] i_thr_sel,
    input wire logic [DW-1:0] i_thr_data,
    // outputs
    output logic o_fault_output_line,
    output logic o_output_good_flag,
    output logic o_convert_en,
    output logic o_light_alarm,
    output logic o_heavy_alarm,
    output logic o_system_alert,
    output logic [N-1:0] o_alarm_active,
    output logic [2*N-1:0] o_alarm_class,
    output logic [DW-1:0] o_thr_bat_ov,
    output logic [DW-1:0] o_thr_bat_uv,
    output logic [DW-1:0] o_thr_grid_ov,
    output logic [DW-1:0] o_thr_grid_uv
);
    import alarm_pkg::*;

    // ------------------------------------------------------------
    // pin inputs
    // ------------------------------------------------------------
    logic [5:0] pins;
    pin_sync #(.W(6)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin({i_reset_switch, i_fault_clear_input, i_hs_sec_pin, i_hs_pri_pin,
                i_ext_stop_pin, i_hw_oc_pin}),
        .o_level(pins)
    );
    wire hw_oc = pins[0];
    wire ext_stop = pins[1];
    wire hs_pri = pins[2];
    wire hs_sec = pins[3];
    wire clr_pin = pins[4];
    wire clr_sw = pins[5];

    // rising edges of clear pins, so a held switch clears once
    logic clr_pin_q;
    logic clr_sw_q;
    wire clr_pin_rise = clr_pin & ~clr_pin_q;
    wire clr_sw_rise = clr_sw & ~clr_sw_q;
    // [R02] any of three clear sources
    wire clear_req = i_serial_clear | clr_pin_rise | clr_sw_rise;

    // ------------------------------------------------------------
    // adjustable thresholds
    // ------------------------------------------------------------
    logic [DW-1:0] thr_bat_ov_q;
    logic [DW-1:0] thr_bat_uv_q;
    logic [DW-1:0] thr_grid_ov_q;
    logic [DW-1:0] thr_grid_uv_q;
    // fixed limits have no write path at all
    localparam logic [DW-1:0] BAT_OC_LIM = DW'(`BAT_OC_LIMIT);
    localparam logic [DW-1:0] GRID_OC_LIM = DW'(`GRID_OC_LIMIT);
    localparam logic [DW-1:0] FAN_MIN = DW'(`FAN_MIN_RPM);
    localparam logic [DW-1:0] TEMP_LIM = DW'(`TEMP_LIMIT_C);
    localparam logic [DW-1:0] CC_CUR_LIM = DW'(`CC_CUR_LIMIT);
    localparam logic [DW-1:0] CC_PWR_LIM = DW'(`CC_PWR_LIMIT);

    // ------------------------------------------------------------
    // detectors
    // ------------------------------------------------------------
    logic [N-1:0] raw;
    // [R08] battery overvoltage compare
    assign raw[`ALM_BAT_OV] = i_bat_volt > thr_bat_ov_q;
    // [R09] battery undervoltage compare
    assign raw[`ALM_BAT_UV] = i_bat_volt < thr_bat_uv_q;
    // [R10] battery overcurrent fixed
    assign raw[`ALM_BAT_OC] = i_bat_curr > BAT_OC_LIM;
    // [R11] grid compares
    assign raw[`ALM_GRID_OV] = i_grid_volt > thr_grid_ov_q;
    assign raw[`ALM_GRID_UV] = i_grid_volt < thr_grid_uv_q;
    assign raw[`ALM_GRID_OC] = i_grid_curr > GRID_OC_LIM;
    // [R12] comparator trip
    assign raw[`ALM_HW_OC] = hw_oc;
    // [R13] external stop
    assign raw[`ALM_EXT_STOP] = ext_stop;
    // [R14] fan too slow
    assign raw[`ALM_FAN] = i_fan_rpm < FAN_MIN;
    // [R15] heatsink detectors
    assign raw[`ALM_HS_PRI] = hs_pri;
    assign raw[`ALM_HS_SEC] = hs_sec;
    // [R16] internal temperature
    assign raw[`ALM_TEMP] = i_temp_c > TEMP_LIM;
    // [R17] internal abnormality
    assign raw[`ALM_SYS] = i_sys_abnormal;
    // [R18] both limits at once in regen cc
    assign raw[`ALM_CC_LIM] = i_regen_cc & (i_mode == MODE_REGEN) &
        (i_bat_curr > CC_CUR_LIM) & (i_bat_power > CC_PWR_LIM);

    // ------------------------------------------------------------
    // classification
    // ------------------------------------------------------------
    alarm_if #(.N(N)) cif ();
    assign cif.raw = raw;
    assign cif.mode = i_mode;
    alarm_classer u_cls (
        .a(cif.classer)
    );

    // ------------------------------------------------------------
    // per item latches
    // ------------------------------------------------------------
    logic [N-1:0] act_q;
    logic [N-1:0] act_d;
    logic [N-1:0] light_now;
    logic [N-1:0] heavy_now;
    logic [N-1:0] sys_now;
    logic [2*N-1:0] cls_q;
    logic [2*N-1:0] cls_d;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_item
            assign light_now[g] = cif.cls[g] == CLS_LIGHT;
            assign heavy_now[g] = cif.cls[g] == CLS_HEAVY;
            assign sys_now[g] = cif.cls[g] == CLS_SYSTEM;
            wire held_cls = cls_q[2*g+1 -: 2] == CLS_HEAVY;
            wire held_sys = cls_q[2*g+1 -: 2] == CLS_SYSTEM;
            wire new_raise = (cif.cls[g] != CLS_NONE) & ~act_q[g];
            // [R02] heavy latched; a fresh detection beats a clear
            // [R04] system alert ignores every clear request
            // [R06] light follows its cause
            assign act_d[g] = (cif.cls[g] != CLS_NONE) |
                (act_q[g] & held_sys) |
                (act_q[g] & held_cls & ~clear_req);
            // [R21] class captured when raised, kept while active
            assign cls_d[2*g+1 -: 2] = new_raise ? cif.cls[g] :
                act_d[g] ? cls_q[2*g+1 -: 2] : CLS_NONE;
        end
    endgenerate

    wire any_light = |(act_d & light_now & ~heavy_now);
    wire any_heavy_cls;
    wire any_sys_cls;
    logic [N-1:0] held_heavy;
    logic [N-1:0] held_sys;
    generate
        for (g = 0; g < N; g++) begin : g_sum
            assign held_heavy[g] = act_d[g] & (cls_d[2*g+1 -: 2] == CLS_HEAVY);
            assign held_sys[g] = act_d[g] & (cls_d[2*g+1 -: 2] == CLS_SYSTEM);
        end
    endgenerate
    assign any_heavy_cls = |held_heavy;
    assign any_sys_cls = |held_sys;

    // ------------------------------------------------------------
    // supervisor state
    // ------------------------------------------------------------
    sup_state_type state_q;
    sup_state_type state_d;
    always_comb begin
        case (1'b1)
            any_sys_cls: state_d = ST_SYSTEM;
            any_heavy_cls: state_d = ST_HEAVY;
            any_light: state_d = ST_LIGHT;
            default: state_d = ST_RUN;
        endcase
    end

    // [R01] heavy or system drives fault line
    wire fault_d = (state_d == ST_HEAVY) | (state_d == ST_SYSTEM);
    // [R03] restart only with a valid operation command
    // [R06] light clears and conversion resumes if command valid
    wire conv_d = (state_d == ST_RUN) & i_run_cmd & (i_mode != MODE_WAIT);
    // [R05] any alarm opens output good; light leaves fault line off
    wire good_d = conv_d;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            clr_pin_q <= 1'b0;
            clr_sw_q <= 1'b0;
            act_q <= '0;
            cls_q <= '0;
            state_q <= ST_RUN;
            o_fault_output_line <= 1'b0;
            o_output_good_flag <= 1'b0;
            o_convert_en <= 1'b0;
            o_light_alarm <= 1'b0;
            o_heavy_alarm <= 1'b0;
            o_system_alert <= 1'b0;
        end else begin
            clr_pin_q <= clr_pin;
            clr_sw_q <= clr_sw;
            act_q <= act_d;
            cls_q <= cls_d;
            state_q <= state_d;
            o_fault_output_line <= fault_d;
            o_output_good_flag <= good_d;
            o_convert_en <= conv_d;
            // summary flags registered so the pins never glitch on decode
            o_light_alarm <= state_d == ST_LIGHT;
            o_heavy_alarm <= state_d == ST_HEAVY;
            o_system_alert <= state_d == ST_SYSTEM;
        end
    end

    // [R19] only adjustable thresholds have a write path
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            thr_bat_ov_q <= DW'(`BAT_OV_RST);
            thr_bat_uv_q <= DW'(`BAT_UV_RST);
            thr_grid_ov_q <= DW'(`GRID_OV_RST);
            thr_grid_uv_q <= DW'(`GRID_UV_RST);
        end else if (i_thr_wr) begin
            case (i_thr_sel)
                `THR_BAT_OV: thr_bat_ov_q <= i_thr_data;
                `THR_BAT_UV: thr_bat_uv_q <= i_thr_data;
                `THR_GRID_OV: thr_grid_ov_q <= i_thr_data;
                `THR_GRID_UV: thr_grid_uv_q <= i_thr_data;
                default: thr_bat_ov_q <= thr_bat_ov_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    // [R07] status for serial readout
    assign o_alarm_active = act_q;
    assign o_alarm_class = cls_q;
    assign o_thr_bat_ov = thr_bat_ov_q;
    assign o_thr_bat_uv = thr_bat_uv_q;
    assign o_thr_grid_ov = thr_grid_ov_q;
    assign o_thr_grid_uv = thr_grid_uv_q;
endmodule

/* hdl/alarm_defs.svh */
// constants for the converter alarm supervisor
`ifndef ALARM_DEFS_SVH
`define ALARM_DEFS_SVH

// ----------------------------------------------------------------
// alarm item indices
// ----------------------------------------------------------------
`define ALM_BAT_OV 4'd0
`define ALM_BAT_UV 4'd1
`define ALM_BAT_OC 4'd2
`define ALM_GRID_OV 4'd3
`define ALM_GRID_UV 4'd4
`define ALM_GRID_OC 4'd5
`define ALM_HW_OC 4'd6
`define ALM_EXT_STOP 4'd7
`define ALM_FAN 4'd8
`define ALM_HS_PRI 4'd9
`define ALM_HS_SEC 4'd10
`define ALM_TEMP 4'd11
`define ALM_SYS 4'd12
`define ALM_CC_LIM 4'd13
`define ALM_COUNT 14

// ----------------------------------------------------------------
// fixed thresholds and reset values
// ----------------------------------------------------------------
// battery current, 0.1 A units
`define BAT_OC_LIMIT 16'h0258
// grid current, 0.1 A units
`define GRID_OC_LIMIT 16'h005a
// fan speed, rpm
`define FAN_MIN_RPM 16'h03e8
// internal temperature, degree C
`define TEMP_LIMIT_C 16'h0035
// cc limit: 8.7 A in 0.1 A units, 2750 W in watts
`define CC_CUR_LIMIT 16'h0057
`define CC_PWR_LIMIT 16'h0abe
// adjustable threshold reset values, 0.1 V units
`define BAT_OV_RST 16'h0258
`define BAT_UV_RST 16'h0168
`define GRID_OV_RST 16'h0ed8
`define GRID_UV_RST 16'h0bb8
// threshold select codes for host writes
`define THR_BAT_OV 2'h0
`define THR_BAT_UV 2'h1
`define THR_GRID_OV 2'h2
`define THR_GRID_UV 2'h3

`endif

/* hdl/alarm_pkg.sv */
// types for the converter alarm supervisor
package alarm_pkg;

    // operation modes
    typedef enum logic [2:0] {
        MODE_WAIT = 3'b000,
        MODE_GEN = 3'b001,
        MODE_REGEN = 3'b010,
        MODE_BAT_AUTO = 3'b011,
        MODE_GRID_AUTO = 3'b100,
        MODE_RAMP = 3'b101
    } op_mode_type;

    // class of an alarm item in a mode
    typedef enum logic [1:0] {
        CLS_NONE = 2'b00,
        CLS_LIGHT = 2'b01,
        CLS_HEAVY = 2'b10,
        CLS_SYSTEM = 2'b11
    } alarm_class_type;

    // supervisor state
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_LIGHT = 2'b01,
        ST_HEAVY = 2'b10,
        ST_SYSTEM = 2'b11
    } sup_state_type;

endpackage

/* hdl/alarm_if.sv */
// detection vector and class table passed between the supervisor modules
`timescale 1ns/100ps
interface alarm_if #(parameter int N = 14);
    logic [N-1:0] raw;
    alarm_pkg::op_mode_type mode;
    alarm_pkg::alarm_class_type cls [N];

    modport classer (input raw, input mode, output cls);
    modport user (output raw, output mode, input cls);
endinterface

/* hdl/alarm_classer.sv */
// mode dependent classification of each alarm item
`timescale 1ns/100ps
module alarm_classer (
    alarm_if.classer a
);
    import alarm_pkg::*;

    // ------------------------------------------------------------
    // class table, one row per item or group of items, default row for the rest
    // ------------------------------------------------------------
    function automatic alarm_class_type class_of(input int idx, input op_mode_type m);
        alarm_class_type c;
        c = CLS_HEAVY;
        case (idx)
            // [R08] battery overvoltage class
            0: c = (m == MODE_WAIT || m == MODE_REGEN || m == MODE_GRID_AUTO) ?
                CLS_LIGHT : CLS_HEAVY;
            // [R09] battery undervoltage class
            1: c = (m == MODE_WAIT) ? CLS_LIGHT : (m == MODE_RAMP) ? CLS_NONE : CLS_HEAVY;
            // [R11] grid voltage class
            3, 4: c = (m == MODE_WAIT || m == MODE_GEN) ? CLS_LIGHT : CLS_HEAVY;
            // [R12] hardware overcurrent class
            6: c = (m == MODE_WAIT) ? CLS_NONE : CLS_HEAVY;
            // [R14] fan fault class
            8: c = (m == MODE_WAIT || m == MODE_RAMP) ? CLS_NONE : CLS_HEAVY;
            // [R16] internal temperature class
            11: c = (m == MODE_BAT_AUTO || m == MODE_RAMP) ? CLS_HEAVY : CLS_LIGHT;
            // [R17] system alert class
            12: c = CLS_SYSTEM;
            // [R10] battery and grid overcurrent, stop, heatsink, cc shutdown always heavy
            default: c = CLS_HEAVY;
        endcase
        return c;
    endfunction

    genvar g;
    generate
        for (g = 0; g < $size(a.cls); g++) begin : g_cls
            assign a.cls[g] = a.raw[g] ? class_of(g, a.mode) : CLS_NONE;
        end
    endgenerate
endmodule

/* hdl/pin_sync.sv */
// three stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;
    wire [W-1:0] agree = ~(s2_q ^ s3_q);
    wire [W-1:0] lvl_d = (agree & s2_q) | (~agree & lvl_q);

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end
    assign o_level = lvl_q;
endmodule

/* verif/alarm_supervisor_checker.sv */
// port level assertions for the alarm supervisor
`timescale 1ns/100ps
`include "alarm_defs.svh"
module alarm_supervisor_checker #(
    parameter int N = 14,
    parameter int DW = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [DW-1:0] i_bat_curr,
    input wire logic i_sys_abnormal,
    input wire alarm_pkg::op_mode_type i_mode,
    input wire logic i_run_cmd,
    input wire logic i_serial_clear,
    input wire logic i_fault_clear_input,
    input wire logic i_reset_switch,
    input wire logic o_fault_output_line,
    input wire logic o_output_good_flag,
    input wire logic o_convert_en,
    input wire logic o_light_alarm,
    input wire logic o_heavy_alarm,
    input wire logic o_system_alert,
    input wire logic [N-1:0] o_alarm_active,
    input wire logic [2*N-1:0] o_alarm_class
);
    import alarm_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // ----------------------------------------------------------------
    // cycles since any clear request, saturating
    // ----------------------------------------------------------------
    logic any_clr;
    logic [3:0] clr_age_q;
    logic [3:0] clr_age_d;
    assign any_clr = i_serial_clear | i_fault_clear_input | i_reset_switch;
    assign clr_age_d = any_clr ? 4'h0 : clr_age_q + {3'h0, clr_age_q != 4'hf};
    always_ff @(posedge i_clk) begin
        clr_age_q <= i_rst ? 4'h0 : clr_age_d;
    end
    sequence heavy_gone;
        $fell(o_heavy_alarm) ##0 (!o_light_alarm && !o_system_alert);
    endsequence
    sequence run_held;
        i_run_cmd && $past(i_run_cmd) && i_mode != MODE_WAIT && $past(i_mode) != MODE_WAIT;
    endsequence
    fault_heavy_a: assert property (
        o_heavy_alarm |-> o_fault_output_line && !o_output_good_flag && !o_convert_en)
        else $error("heavy alarm without fault line or with output good");
    light_quiet_a: assert property (
        o_light_alarm |-> !o_fault_output_line && !o_output_good_flag && !o_convert_en)
        else $error("light alarm drove fault line or kept conversion");
    heavy_latch_a: assert property (
        o_alarm_active[`ALM_BAT_OC] && !any_clr && clr_age_q >= 4'h8
        |=> o_alarm_active[`ALM_BAT_OC])
        else $error("heavy item dropped without a clear request");
    clear_restart_a: assert property (
        heavy_gone ##0 run_held |-> ##[0:1] o_convert_en)
        else $error("conversion did not restart after clear");
    run_gate_a: assert property (
        !i_run_cmd |=> !o_convert_en)
        else $error("conversion without operation command");
    sys_hold_a: assert property (
        o_system_alert |=> o_system_alert && o_fault_output_line)
        else $error("system alert cleared before reset");
    sys_raise_a: assert property (
        i_sys_abnormal |=> o_system_alert && o_fault_output_line)
        else $error("abnormality did not raise system alert");
    bat_oc_a: assert property (
        i_bat_curr > `BAT_OC_LIMIT |=> o_alarm_active[`ALM_BAT_OC]
        && o_alarm_class[5:4] == CLS_HEAVY && o_fault_output_line)
        else $error("battery overcurrent not raised as heavy");
endmodule
bind alarm_supervisor alarm_supervisor_checker #(.N(N), .DW(DW)) chk (.*);

/* verif/host_model.sv */
// host and signal connector model on the supervisor's command side
`timescale 1ns/100ps
module host_model (
    input wire logic i_clk,
    output logic o_serial_clear,
    output logic o_fault_clear_input,
    output logic o_reset_switch,
    output logic o_run_cmd,
    output logic o_thr_wr,
    output logic [1:0] o_thr_sel,
    output logic [15:0] o_thr_data
);
    // ----------------------------------------------------------------
    // clear and write requests, each started one edge after the previous one
    // ----------------------------------------------------------------
    initial begin
        {o_serial_clear, o_fault_clear_input, o_reset_switch, o_run_cmd, o_thr_wr} = 5'h00;
        o_thr_sel = 2'h0;
        o_thr_data = 16'h0000;
    end
    // clear source 0 serial, 1 clear pin, 2 push switch
    // pins pass a filter, so they are held well past its depth
    task automatic clear(input int src);
        @(posedge i_clk);
        #1;
        o_serial_clear = (src == 0);
        o_fault_clear_input = (src == 1);
        o_reset_switch = (src == 2);
        repeat ((src == 0) ? 1 : 6) @(posedge i_clk);
        #1;
        {o_serial_clear, o_fault_clear_input, o_reset_switch} = 3'h0;
    endtask
    task automatic write(input logic [1:0] sel, input logic [15:0] data);
        @(posedge i_clk);
        #1;
        o_thr_wr = 1'b1;
        o_thr_sel = sel;
        o_thr_data = data;
        @(posedge i_clk);
        #1;
        o_thr_wr = 1'b0;
        // released data must not look valid
        o_thr_data = ~data;
    endtask
    task automatic set_run(input logic run);
        o_run_cmd = run;
    endtask
endmodule

/* verif/tb.sv */
// self-checking testbench for the alarm supervisor
`timescale 1ns/100ps
`include "alarm_defs.svh"
module tb;
    import alarm_pkg::*;
    // ----------------------------------------------------------------
    // stimulus, model and checks
    // ----------------------------------------------------------------
    // class per item, two bits per mode, waiting mode lowest
    localparam logic [11:0] CLS_TBL [12] = '{12'h999, 12'h2a9, 12'haaa, 12'haa5, 12'haa5,
        12'haaa, 12'haa8, 12'haaa, 12'h2a8, 12'haaa, 12'haaa, 12'h995};
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [15:0] i_bat_volt, i_bat_curr, i_grid_volt, i_grid_curr, i_fan_rpm, i_temp_c;
    logic [15:0] i_bat_power, i_thr_data, o_thr_bat_ov, o_thr_bat_uv, o_thr_grid_ov, o_thr_grid_uv;
    logic i_regen_cc, i_hw_oc_pin, i_ext_stop_pin, i_hs_pri_pin, i_hs_sec_pin, i_sys_abnormal;
    logic i_serial_clear, i_fault_clear_input, i_reset_switch, i_run_cmd, i_thr_wr;
    logic o_fault_output_line, o_output_good_flag, o_convert_en, o_light_alarm, o_heavy_alarm;
    logic o_system_alert;
    logic [1:0] i_thr_sel, exp_cls;
    logic [13:0] o_alarm_active;
    logic [27:0] o_alarm_class;
    op_mode_type i_mode;
    int mismatches = 0;
    int tests_run = 0;
    always #5 i_clk = ~i_clk;
    alarm_supervisor DUT (.*);
    host_model host (.i_clk(i_clk), .o_serial_clear(i_serial_clear),
        .o_fault_clear_input(i_fault_clear_input), .o_reset_switch(i_reset_switch),
        .o_run_cmd(i_run_cmd), .o_thr_wr(i_thr_wr), .o_thr_sel(i_thr_sel),
        .o_thr_data(i_thr_data));
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (exp !== got) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic normal();
        {i_bat_volt, i_bat_curr, i_grid_volt, i_grid_curr} = {16'h01f4, 16'h0, 16'h0d00, 16'h0};
        {i_fan_rpm, i_temp_c, i_bat_power} = {16'h07d0, 16'h0019, 16'h0};
        {i_regen_cc, i_hw_oc_pin, i_ext_stop_pin, i_hs_pri_pin, i_hs_sec_pin} = 5'h00;
        i_sys_abnormal = 1'b0;
    endtask
    task automatic cause(input int item, input logic on);
        case (item)
            0: i_bat_volt = on ? 16'h0259 : 16'h01f4;
            1: i_bat_volt = on ? 16'h0167 : 16'h01f4;
            2: i_bat_curr = on ? 16'h0259 : 16'h0000;
            3: i_grid_volt = on ? 16'h0ed9 : 16'h0d00;
            4: i_grid_volt = on ? 16'h0bb7 : 16'h0d00;
            5: i_grid_curr = on ? 16'h005b : 16'h0000;
            6: i_hw_oc_pin = on;
            7: i_ext_stop_pin = on;
            8: i_fan_rpm = on ? 16'h03e7 : 16'h07d0;
            9: i_hs_pri_pin = on;
            10: i_hs_sec_pin = on;
            default: i_temp_c = on ? 16'h0036 : 16'h0019;
        endcase
    endtask
    initial begin
        normal();
        i_mode = MODE_GEN;
        tick(20);
        i_rst = 1'b0;
        check("thr_bat_uv", `BAT_UV_RST, o_thr_bat_uv);
        check("thr_grid_ov", `GRID_OV_RST, o_thr_grid_ov);
        i_bat_volt = 16'h0258;
        host.set_run(1'b1);
        for (int k = 0; k <= 10; k++) begin
            if (k == 10) begin
                check("conv_start", 16'h1, o_convert_en);
                final_report();
            end
            if (o_convert_en === 1'b1) begin
                break;
            end
            tick(1);
        end
        check("good", 16'h1, o_output_good_flag);
        check("at_thr", 16'h0, o_alarm_active);
        normal();
        for (int s = 0; s < 3; s++) begin
            host.set_run(s != 2);
            cause(2, 1'b1);
            tick(1);
            check("oc_good", 16'h0, o_output_good_flag);
            check("oc_heavy", 16'h1, o_heavy_alarm);
            cause(2, 1'b0);
            tick(3);
            check("oc_held", 16'h1, o_alarm_active[2]);
            host.clear(s);
            tick(1);
            check("oc_fault", 16'h0, o_fault_output_line);
            check("restart", 16'(s != 2), o_convert_en);
        end
        host.set_run(1'b1);
        i_mode = MODE_REGEN;
        cause(0, 1'b1);
        tick(2);
        check("light", 16'h1, o_light_alarm);
        cause(0, 1'b0);
        tick(2);
        check("self_clear", 16'h1, o_convert_en);
        {i_regen_cc, i_bat_curr, i_bat_power} = {1'b1, 16'h0058, 16'h0abe};
        tick(2);
        check("cc_one", 16'h0, o_alarm_active[13]);
        i_bat_power = 16'h0abf;
        tick(1);
        check("cc_both", 16'h1, o_alarm_active[13]);
        normal();
        host.clear(0);
        for (int m = 0; m < 6; m++) begin
            i_mode = op_mode_type'(m);
            for (int it = 0; it < 12; it++) begin
                exp_cls = CLS_TBL[it][2*m +: 2];
                cause(it, 1'b1);
                tick(6);
                check("class", 16'(exp_cls), o_alarm_class[2*it +: 2]);
                check("fault", 16'(exp_cls == 2'h2), o_fault_output_line);
                check("conv", 16'(exp_cls == 2'h0 && m != 0), o_convert_en);
                cause(it, 1'b0);
                tick(6);
                host.clear(0);
                tick(1);
                check("idle", 16'h0, o_alarm_active);
            end
        end
        i_mode = MODE_GEN;
        host.write(`THR_BAT_OV, 16'h0300);
        host.write(`THR_BAT_UV, 16'h0101);
        host.write(`THR_GRID_OV, 16'h0f00);
        host.write(`THR_GRID_UV, 16'h0a00);
        check("wr_bat_ov", 16'h0300, o_thr_bat_ov);
        check("wr_bat_uv", 16'h0101, o_thr_bat_uv);
        check("wr_grid_ov", 16'h0f00, o_thr_grid_ov);
        check("wr_grid_uv", 16'h0a00, o_thr_grid_uv);
        cause(0, 1'b1);
        tick(2);
        check("new_thr", 16'h0, o_alarm_active);
        cause(0, 1'b0);
        i_sys_abnormal = 1'b1;
        tick(1);
        i_sys_abnormal = 1'b0;
        for (int s = 0; s < 3; s++) begin
            host.clear(s);
        end
        tick(1);
        check("sys_held", 16'h1, o_system_alert);
        check("sys_class", 16'h3, o_alarm_class[25:24]);
        host.set_run(1'b0);
        i_rst = 1'b1;
        tick(2);
        i_rst = 1'b0;
        tick(1);
        check("sys_gone", 16'h0, o_fault_output_line);
        check("thr_back", `BAT_OV_RST, o_thr_bat_ov);
        final_report();
    end
endmodule
